// file: src/sipsd_pkg.sv
// Shared constants and types for the serial-in, parallel-out sink driver.
// Assumes one system clock domain plus the controller's shift clock domain.
package sipsd_pkg;

    // ==========================================================
    // Geometry
    localparam int STAGE_COUNT = 12;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // Reset and idle values
    localparam logic [11:0] STORE_RESET = 12'h000;
    localparam logic [11:0] DRAIN_LEVEL = 12'h000;
    localparam logic [11:0] OE_N_ALL_OFF = 12'hfff;

    // ==========================================================
    // Bit positions inside the pin synchroniser vector
    localparam int SYNC_LATCH = 0;
    localparam int SYNC_CLEAR = 1;
    localparam int SYNC_OE = 2;
    localparam int SYNC_TRIP = 3;
    localparam int SYNC_RELEASE = 4;
    localparam int SYNC_SHIFT_LSB = 5;
    localparam int SYNC_DRAIN_LSB = SYNC_SHIFT_LSB + STAGE_COUNT;
    localparam int SYNC_WIDTH = SYNC_DRAIN_LSB + STAGE_COUNT;

    // ==========================================================
    // Thermal protection states
    typedef enum logic [0:0]
    {
        THERM_RUN = 1'b0,
        THERM_OFF = 1'b1
    } sipsd_therm_type;

endpackage : sipsd_pkg

// file: src/sipsd_fifo.sv
// Synchronous FIFO carrying latched words toward the storage register.
// Assumes DEPTH is a power of two; flush empties it in one edge.
`timescale 1ns/100ps
`default_nettype none
module sipsd_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_en,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    // ==========================================================
    // Flags
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

    // ==========================================================
    // Storage and pointers
    always_ff @(posedge clock)
    begin
        if (clock_en && push)
        begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || (clock_en && flush))
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else if (clock_en)
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

endmodule : sipsd_fifo
`default_nettype wire

// file: src/sipsd_driver.sv
// Twelve-stage serial-in, parallel-out sink driver with storage register,
// gated open-drain outputs and thermal shutdown.
// Assumes shift_clock comes from the controller and may stop between frames;
// serial_in follows it; all other pins are asynchronous to clock and are synchronised here.
//
// Behaviour
// - twelve shift stages feed twelve-bit storage register
// - shift clock rise shifts, captures serial input
// - latch clock rise copies shift stages to storage
// - storage reaches outputs only while clear high
// - clear low zeroes shift stages, serial output, storage and buffer, flushes FIFO
// - enable high forces all outputs off
// - enable low makes outputs follow storage register
// - buffer bit high sinks, low is off
// - serial output updates on shift clock fall
// - cascaded devices share shift clock, chain data
// - outputs change at latch clock rise
// - overtemperature forces outputs open until release
`timescale 1ns/100ps
`default_nettype none
module sipsd_driver #(
    parameter int STAGES = sipsd_pkg::STAGE_COUNT,
    parameter int DEPTH = sipsd_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_en,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic latch_clock,
    input wire logic clear_n,
    input wire logic output_enable_n,
    input wire logic over_temp_trip,
    input wire logic over_temp_release,
    input wire logic [STAGES-1:0] drain_in,
    output logic [STAGES-1:0] drain_out,
    output logic [STAGES-1:0] drain_oe_n,
    output logic serial_out,
    output logic latch_ready,
    output logic thermal_shutdown,
    output logic [STAGES-1:0] drain_fault
);
    import sipsd_pkg::*;

    // ==========================================================
    // Declarations
    logic [STAGES-1:0] shift_reg;
    logic serial_out_reg;
    logic [SYNC_WIDTH-1:0] sync1_reg;
    logic [SYNC_WIDTH-1:0] sync2_reg;
    logic latch_prev_reg;
    logic latch_s;
    logic clear_s;
    logic oe_n_s;
    logic trip_s;
    logic release_s;
    logic [STAGES-1:0] shift_s;
    logic [STAGES-1:0] drain_s;
    logic latch_rise;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [STAGES-1:0] fifo_out_data;
    logic [STAGES-1:0] storage_reg;
    logic [STAGES-1:0] buffer_reg;
    logic [STAGES-1:0] buffer_next;
    logic [STAGES-1:0] drain_oe_n_reg;
    logic [STAGES-1:0] drain_fault_reg;
    sipsd_therm_type therm_reg;
    sipsd_therm_type therm_next;

    // ==========================================================
    // Shift stages on the controller's clock
    // Clear acts without a clock edge, so a stopped shift clock cannot
    // leave stale data behind.
    always_ff @(posedge shift_clock or negedge clear_n)
    begin
        if (!clear_n)
        begin
            shift_reg <= STORE_RESET;
        end
        else
        begin
            // Stage 0 takes the pin; the first bit walks up to the last stage
            shift_reg <= {shift_reg[STAGES-2:0], serial_in};
        end
    end

    // Launching on the falling edge gives the next device half a period
    // of hold on a shared, possibly skewed shift clock.
    always_ff @(negedge shift_clock or negedge clear_n)
    begin
        if (!clear_n)
        begin
            serial_out_reg <= 1'b0;
        end
        else
        begin
            serial_out_reg <= shift_reg[STAGES-1];
        end
    end

    assign serial_out = serial_out_reg;

    // ==========================================================
    // Pin synchronisers
    // The shift stages are quasi-static when the latch edge arrives, so
    // they cross on the same two flops as the latch strobe that qualifies
    // them. Limitation: the controller must keep shift_clock idle for at
    // least three system clocks around each latch rise.
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (clock_en)
        begin
            sync1_reg <= {drain_in, shift_reg, over_temp_release, over_temp_trip,
                          output_enable_n, clear_n, latch_clock};
            sync2_reg <= sync1_reg;
        end
    end

    assign latch_s = sync2_reg[SYNC_LATCH];
    assign clear_s = sync2_reg[SYNC_CLEAR];
    assign oe_n_s = sync2_reg[SYNC_OE];
    assign trip_s = sync2_reg[SYNC_TRIP];
    assign release_s = sync2_reg[SYNC_RELEASE];
    assign shift_s = sync2_reg[SYNC_SHIFT_LSB +: STAGES];
    assign drain_s = sync2_reg[SYNC_DRAIN_LSB +: STAGES];

    // ==========================================================
    // Latch edge detection
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            latch_prev_reg <= 1'b0;
        end
        else if (clock_en)
        begin
            latch_prev_reg <= latch_s;
        end
    end

    // A latch rise while cleared carries nothing: the shift stages are zero
    assign latch_rise = latch_s && !latch_prev_reg && clear_s;

    // ==========================================================
    // Word buffer between latch and storage
    // Draining stalls during thermal shutdown so latched words are kept in
    // order and applied once the part recovers; when full, latches are
    // refused and latch_ready shows it.
    assign fifo_out_ready = (therm_reg == THERM_RUN);

    sipsd_fifo #(
        .WIDTH(STAGES),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .clock_en(clock_en),
        .flush(!clear_s),
        .in_valid(latch_rise),
        .in_ready(fifo_in_ready),
        .in_data(shift_s),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign latch_ready = fifo_in_ready;

    // ==========================================================
    // Storage register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            storage_reg <= STORE_RESET;
        end
        else if (clock_en)
        begin
            if (!clear_s)
            begin
                storage_reg <= STORE_RESET;
            end
            else if (fifo_out_valid && fifo_out_ready)
            begin
                storage_reg <= fifo_out_data;
            end
        end
    end

    // ==========================================================
    // Thermal protection
    always_comb
    begin
        therm_next = therm_reg;
        unique case (therm_reg)
            THERM_RUN:
            begin
                if (trip_s)
                begin
                    therm_next = THERM_OFF;
                end
            end
            THERM_OFF:
            begin
                // Hysteresis: only the lower release level lets it run again
                if (release_s && !trip_s)
                begin
                    therm_next = THERM_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            therm_reg <= THERM_RUN;
        end
        else if (clock_en)
        begin
            therm_reg <= therm_next;
        end
    end

    assign thermal_shutdown = (therm_reg == THERM_OFF);

    // ==========================================================
    // Output buffer and open-drain pins
    // The buffer follows storage each cycle, not on an edge of its own, so
    // pulsing the enable dims all channels together.
    always_comb
    begin
        if (clear_s && !oe_n_s && (therm_reg == THERM_RUN))
        begin
            buffer_next = storage_reg;
        end
        else
        begin
            buffer_next = STORE_RESET;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            buffer_reg <= STORE_RESET;
            drain_oe_n_reg <= OE_N_ALL_OFF;
        end
        else if (clock_en)
        begin
            buffer_reg <= buffer_next;
            drain_oe_n_reg <= ~buffer_next;
        end
    end

    // A sinking drain only ever pulls low
    assign drain_out = DRAIN_LEVEL;
    assign drain_oe_n = drain_oe_n_reg;

    // A driven drain that still reads high points at an open or shorted load
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            drain_fault_reg <= STORE_RESET;
        end
        else if (clock_en)
        begin
            drain_fault_reg <= buffer_reg & drain_s;
        end
    end

    assign drain_fault = drain_fault_reg;

    // ==========================================================
    // Checks on the link side
    a_shift_moves: assert property (@(posedge shift_clock) disable iff (!clear_n)
        ##1 (shift_reg[STAGES-1:1] == $past(shift_reg[STAGES-2:0])) &&
            (shift_reg[0] == $past(serial_in)))
        else $error("shift stages did not advance by one place");

    a_serial_out_fall: assert property (@(posedge shift_clock) disable iff (!clear_n)
        serial_out == shift_reg[STAGES-1])
        else $error("serial output not launched on the falling edge");

    // ==========================================================
    // Checks on the system side
    a_clear_stages: assert property (@(posedge clock) disable iff (sys_rst)
        !clear_s |-> (shift_s == STORE_RESET))
        else $error("shift stages not cleared while clear held low");

    a_latch_store: assert property (@(posedge clock) disable iff (sys_rst || !clear_s)
        (latch_rise && clock_en && !fifo_out_valid && therm_reg == THERM_RUN) |->
            ##2 (storage_reg == $past(shift_s, 2)))
        else $error("latched word did not reach storage in two cycles");

    a_clear_storage: assert property (@(posedge clock) disable iff (sys_rst)
        (!clear_s && clock_en) |=> (storage_reg == STORE_RESET))
        else $error("storage not cleared by clear");

    a_clear_gates: assert property (@(posedge clock) disable iff (sys_rst)
        (!clear_s && clock_en) |=> (drain_oe_n == OE_N_ALL_OFF))
        else $error("outputs active while clear low");

    a_enable_off: assert property (@(posedge clock) disable iff (sys_rst)
        (oe_n_s && clock_en) |=> (drain_oe_n == OE_N_ALL_OFF))
        else $error("outputs active while enable high");

    a_enable_follow: assert property (@(posedge clock) disable iff (sys_rst)
        (clock_en && !oe_n_s && clear_s && therm_reg == THERM_RUN) |=>
            (drain_oe_n == ~$past(storage_reg)))
        else $error("outputs do not follow storage while enabled");

    a_therm_trip: assert property (@(posedge clock) disable iff (sys_rst)
        (trip_s && clock_en) |=> thermal_shutdown ##1 (drain_oe_n == OE_N_ALL_OFF))
        else $error("overtemperature did not force outputs open");

    a_therm_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (thermal_shutdown && !release_s) |=> thermal_shutdown)
        else $error("thermal shutdown left before release level");

    a_drain_level: assert property (@(posedge clock) disable iff (sys_rst)
        (drain_out == DRAIN_LEVEL) && ((~drain_oe_n & ~buffer_reg) == STORE_RESET))
        else $error("drain driven without a set buffer bit");

endmodule : sipsd_driver
`default_nettype wire

// file: bench/sipsd_ctrl_model.sv
// Controller model: drives the link clock, serial data and latch pin.
// Assumes the bench calls one task at a time; the link clock idles low.
`timescale 1ns/100ps
`default_nettype none
module sipsd_ctrl_model (
    output logic shift_clock,
    output logic serial_in,
    output logic latch_clock,
    input wire logic serial_out
);
    logic [11:0] so_hi;
    logic [11:0] so_lo;

    initial
    begin
        shift_clock = 1'b0;
        serial_in = 1'b1;
        latch_clock = 1'b0;
    end

    // ==========================================================
    // Frame: word bit 11 goes first so it ends in the last stage
    task automatic send(input logic [11:0] w);
        #7;
        serial_in = w[11];
        #31;
        for (int i = 0; i < 12; i++)
        begin
            shift_clock = 1'b1;
            #31 so_hi[i] = serial_out;
            #31.5 shift_clock = 1'b0;
            // Data moves on the fall, as a cascaded upstream part would
            serial_in = (i < 11) ? w[10-i] : ~w[0];
            #31 so_lo[i] = serial_out;
            #31.5;
        end
        // Link clock stays still well clear of the latch rise
        #200;
    endtask : send

    task automatic latch();
        latch_clock = 1'b1;
        #200 latch_clock = 1'b0;
        #400;
    endtask : latch
endmodule : sipsd_ctrl_model
`default_nettype wire

// file: bench/sipsd_driver_bench.sv
// Self-checking bench for the sink driver: frames, latching, gating, FIFO.
// Assumes sipsd_ctrl_model as the controller and the design package.
`timescale 1ns/100ps
`default_nettype none
module sipsd_driver_bench;
    import sipsd_pkg::*;
    logic clock, sys_rst, clock_en, clear_n, output_enable_n, trip, rel;
    logic shift_clock, serial_in, latch_clock, serial_out, latch_ready, thermal_shutdown;
    logic [11:0] drain_in, drain_out, drain_oe_n, drain_fault, inj, cur;
    int n_mismatch = 0;
    int checks_done = 0;

    sipsd_driver #(.STAGES(STAGE_COUNT), .DEPTH(FIFO_DEPTH)) DUT (
        .clock(clock), .sys_rst(sys_rst), .clock_en(clock_en),
        .shift_clock(shift_clock), .serial_in(serial_in), .latch_clock(latch_clock),
        .clear_n(clear_n), .output_enable_n(output_enable_n),
        .over_temp_trip(trip), .over_temp_release(rel), .drain_in(drain_in),
        .drain_out(drain_out), .drain_oe_n(drain_oe_n), .serial_out(serial_out),
        .latch_ready(latch_ready), .thermal_shutdown(thermal_shutdown),
        .drain_fault(drain_fault)
    );

    sipsd_ctrl_model u_ctrl (
        .shift_clock(shift_clock), .serial_in(serial_in),
        .latch_clock(latch_clock), .serial_out(serial_out)
    );

    initial
    begin
        clock = 1'b0;
    end

    always #25 clock = ~clock;

    // Pin readback: pulled high when off, low when sinking, inj breaks it
    always @(posedge clock) drain_in <= drain_oe_n ^ inj;

    // ==========================================================
    // Helpers
    task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask : cyc

    function automatic logic [11:0] wd(input int i);
        return 12'(i * 12'h0b7);
    endfunction : wd

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        // A real falling edge is needed to fire the asynchronous clear
        @(posedge clock) clear_n <= 1'b0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        clear_n <= 1'b1;
        cyc(4);
        chk("oe_n", drain_oe_n, OE_N_ALL_OFF);
        chk("serial_out", {11'h000, serial_out}, 12'h000);
        chk("ready", {11'h000, latch_ready}, 12'h001);
        chk("fault", drain_fault, 12'h000);
        chk("drain_out", drain_out, DRAIN_LEVEL);
        cur = OE_N_ALL_OFF;
        $display("t_reset done");
    endtask : t_reset

    task automatic t_load();
        logic [11:0] w [3] = '{12'h001, 12'h800, 12'ha5c};
        for (int k = 0; k < 3; k++)
        begin
            u_ctrl.send(w[k]);
            chk("oe_n before latch", drain_oe_n, cur);
            u_ctrl.latch();
            cur = ~w[k];
            chk("oe_n after latch", drain_oe_n, cur);
            chk("fault", drain_fault, 12'h000);
        end
        @(posedge clock) inj <= 12'h800;
        cyc(5);
        chk("fault inj", drain_fault, 12'h800);
        @(posedge clock) inj <= 12'h000;
        cyc(5);
        $display("t_load done");
    endtask : t_load

    task automatic t_serout();
        logic [11:0] a, b, lo_e, hi_e;
        a = 12'ha5c;
        b = 12'h3c6;
        for (int i = 0; i < 12; i++)
        begin
            lo_e[i] = (i < 11) ? a[10-i] : b[11];
            hi_e[i] = (i == 0) ? a[11] : lo_e[i-1];
        end
        u_ctrl.send(b);
        chk("serial_out fall", u_ctrl.so_lo, lo_e);
        chk("serial_out rise", u_ctrl.so_hi, hi_e);
        u_ctrl.latch();
        cur = ~b;
        chk("oe_n", drain_oe_n, cur);
        $display("t_serout done");
    endtask : t_serout

    task automatic t_enable();
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clock) output_enable_n <= 1'b1;
            cyc(4);
            chk("oe_n gated", drain_oe_n, OE_N_ALL_OFF);
            @(posedge clock) output_enable_n <= 1'b0;
            cyc(4);
            chk("oe_n open", drain_oe_n, cur);
        end
        // Clock enable low freezes the synchronisers and the outputs
        @(posedge clock) clock_en <= 1'b0;
        output_enable_n <= 1'b1;
        cyc(4);
        chk("oe_n frozen", drain_oe_n, cur);
        @(posedge clock) clock_en <= 1'b1;
        cyc(4);
        chk("oe_n unfrozen", drain_oe_n, OE_N_ALL_OFF);
        @(posedge clock) output_enable_n <= 1'b0;
        cyc(4);
        chk("oe_n reopened", drain_oe_n, cur);
        $display("t_enable done");
    endtask : t_enable

    task automatic t_thermal();
        @(posedge clock) trip <= 1'b1;
        rel <= 1'b0;
        cyc(5);
        chk("shutdown", {11'h000, thermal_shutdown}, 12'h001);
        chk("oe_n hot", drain_oe_n, OE_N_ALL_OFF);
        @(posedge clock) trip <= 1'b0;
        cyc(5);
        chk("shutdown hys", {11'h000, thermal_shutdown}, 12'h001);
        for (int i = 1; i <= 17; i++)
        begin
            u_ctrl.send(wd(i));
            u_ctrl.latch();
            chk("oe_n queued", drain_oe_n, OE_N_ALL_OFF);
        end
        chk("ready full", {11'h000, latch_ready}, 12'h000);
        @(posedge clock) rel <= 1'b1;
        cyc(5);
        chk("shutdown off", {11'h000, thermal_shutdown}, 12'h000);
        cyc(40);
        cur = ~wd(16);
        chk("oe_n drained", drain_oe_n, cur);
        chk("ready empty", {11'h000, latch_ready}, 12'h001);
        $display("t_thermal done");
    endtask : t_thermal

    task automatic t_clear();
        u_ctrl.send(12'hfff);
        @(posedge clock) clear_n <= 1'b0;
        cyc(0);
        chk("serial_out clr", {11'h000, serial_out}, 12'h000);
        cyc(4);
        chk("oe_n clr", drain_oe_n, OE_N_ALL_OFF);
        u_ctrl.latch();
        chk("oe_n clr latch", drain_oe_n, OE_N_ALL_OFF);
        @(posedge clock) clear_n <= 1'b1;
        cyc(4);
        chk("oe_n after clr", drain_oe_n, OE_N_ALL_OFF);
        u_ctrl.latch();
        chk("oe_n stages zero", drain_oe_n, OE_N_ALL_OFF);
        $display("t_clear done");
    endtask : t_clear

    initial
    begin
        sys_rst = 1'b1;
        clock_en = 1'b1;
        clear_n = 1'b1;
        output_enable_n = 1'b0;
        trip = 1'b0;
        rel = 1'b1;
        inj = 12'h000;
        t_reset();
        t_load();
        t_serout();
        t_enable();
        t_thermal();
        t_clear();
        summarize();
    end

    // Whole run needs about 60 us; allow a wide margin
    initial
    begin
        #1_000_000;
        n_mismatch++;
        $display("watchdog expired");
        summarize();
    end
endmodule : sipsd_driver_bench
`default_nettype wire
